//--- hdl/prd_decoder.v
// Pulse reference decoder with input filters, error counter and AXI4-Lite registers.
`timescale 1ns/1ps
`include "prd_map.vh"

module prd_filter (
    input wire clk,
    input wire reset_n,
    input wire rawIn,
    input wire [3:0] limit,
    output reg filtOut
);
    reg [3:0] stableCount;

    // A change is passed on only after it has held for limit cycles.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stableCount <= 4'h0;
            filtOut <= 1'b0;
        end else if (rawIn == filtOut) begin
            stableCount <= 4'h0;
        end else if (stableCount >= limit - 4'h1) begin
            stableCount <= 4'h0;
            filtOut <= rawIn;
        end else begin
            stableCount <= stableCount + 4'h1;
        end
    end
endmodule

module prd_decoder (
    input wire clk,
    input wire reset_n,
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire pulseA,
    input wire pulseB,
    input wire errorClearInput,
    input wire baseBlock,
    input wire alarm,
    output reg [31:0] errorCount
);
    localparam integer LD_CYC_FULL = `PRD_FILT_LD_CYC;
    localparam integer OC_CYC_FULL = `PRD_FILT_OC_CYC;
    // Both counts fit the four-bit filter counter, so the upper bits are cut on purpose.
    localparam [3:0] LD_CYC = LD_CYC_FULL[3:0];
    localparam [3:0] OC_CYC = OC_CYC_FULL[3:0];

    reg [8:0] ctrlWord;
    wire [3:0] pulseForm;
    wire [1:0] clearForm;
    wire [1:0] clearOp;
    wire filterSel;
    wire [3:0] filtLimit;
    wire filtA;
    wire filtB;
    wire filtClr;

    assign pulseForm = ctrlWord[`PRD_FORM_MSB:`PRD_FORM_LSB];
    assign clearForm = ctrlWord[`PRD_CLRSIG_MSB:`PRD_CLRSIG_LSB];
    assign clearOp = ctrlWord[`PRD_CLROP_MSB:`PRD_CLROP_LSB];
    assign filterSel = ctrlWord[`PRD_FILT_BIT];

    // The open-collector setting trades response time for noise immunity.
    assign filtLimit = filterSel ? OC_CYC : LD_CYC; // [R12]

    prd_filter filterA (
        .clk(clk),
        .reset_n(reset_n),
        .rawIn(pulseA),
        .limit(filtLimit),
        .filtOut(filtA)
    );

    prd_filter filterB (
        .clk(clk),
        .reset_n(reset_n),
        .rawIn(pulseB),
        .limit(filtLimit),
        .filtOut(filtB)
    );

    prd_filter filterClr (
        .clk(clk),
        .reset_n(reset_n),
        .rawIn(errorClearInput),
        .limit(filtLimit),
        .filtOut(filtClr)
    );

    reg negLogic;
    reg [3:0] baseForm;
    wire curA;
    wire curB;
    reg prevA;
    reg prevB;
    reg prevClr;
    wire aRise;
    wire aEdge;
    wire bRise;
    wire bEdge;
    reg countUp;
    reg countDown;

    // Forms 5 to 9 repeat forms 0 to 4 on inverted inputs.
    always @* begin
        negLogic = 1'b0;
        baseForm = pulseForm;
        if (pulseForm >= `PRD_FORM_NEG_FIRST && pulseForm <= `PRD_FORM_NEG_LAST) begin
            negLogic = 1'b1;
            baseForm = pulseForm - `PRD_FORM_NEG_FIRST;
        end
    end

    assign curA = filtA ^ negLogic;
    assign curB = filtB ^ negLogic;
    assign aRise = curA & ~prevA;
    assign aEdge = curA ^ prevA;
    assign bRise = curB & ~prevB;
    assign bEdge = curB ^ prevB;

    // In the quadrature forms A leading B is forward; a step where both phases move is invalid and dropped.
    always @* begin
        countUp = 1'b0;
        countDown = 1'b0;
        case (baseForm)
            `PRD_FORM_SIGN: begin
                if (aRise) begin
                    countUp = ~curB; // [R01]
                    countDown = curB; // [R01]
                end
            end
            `PRD_FORM_CWCCW: begin
                countUp = aRise & ~bRise; // [R02]
                countDown = bRise & ~aRise; // [R02]
            end
            `PRD_FORM_QX1: begin
                if (aRise && !bEdge) begin
                    countUp = ~curB; // [R03]
                    countDown = curB; // [R03]
                end
            end
            `PRD_FORM_QX2: begin
                if (aEdge && !bEdge) begin
                    countUp = curA ^ prevB; // [R04]
                    countDown = ~(curA ^ prevB); // [R04]
                end
            end
            `PRD_FORM_QX4: begin
                if (aEdge ^ bEdge) begin
                    countUp = curA ^ prevB; // [R05]
                    countDown = ~(curA ^ prevB); // [R05]
                end
            end
            default: begin
                countUp = 1'b0;
                countDown = 1'b0;
            end
        endcase
    end

    reg inputClear;
    wire eventClear;
    wire clearNow;

    always @* begin
        inputClear = 1'b0;
        case (clearForm)
            `PRD_CLRSIG_HIGH: inputClear = filtClr; // [R06]
            `PRD_CLRSIG_RISE: inputClear = filtClr & ~prevClr; // [R07]
            `PRD_CLRSIG_LOW: inputClear = ~filtClr; // [R06]
            `PRD_CLRSIG_FALL: inputClear = ~filtClr & prevClr; // [R08]
            default: inputClear = 1'b0;
        endcase
        if (clearOp == `PRD_CLROP_IGNORE) begin
            inputClear = 1'b0; // [R13]
        end
    end

    // Operation 1 adds no event of its own, so only the input term remains.
    assign eventClear = (clearOp == `PRD_CLROP_BASEBLOCK && baseBlock) || // [R09] [R10]
        (clearOp == `PRD_CLROP_ALARM && alarm); // [R11]
    assign clearNow = inputClear | eventClear;

    // Clearing wins over a count in the same cycle, since a held clear must read zero.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            errorCount <= 32'h00000000;
            prevA <= 1'b0;
            prevB <= 1'b0;
            prevClr <= 1'b0;
        end else begin
            prevA <= curA;
            prevB <= curB;
            prevClr <= filtClr;
            if (clearNow) begin
                errorCount <= 32'h00000000;
            end else if (countUp) begin
                errorCount <= errorCount + 32'h00000001; // [R14]
            end else if (countDown) begin
                errorCount <= errorCount - 32'h00000001; // [R14]
            end
        end
    end

    reg awHave;
    reg wHave;
    reg [7:0] awAddrQ;
    reg [31:0] wDataQ;
    reg [3:0] wStrbQ;

    assign awready = ~awHave & ~bvalid;
    assign wready = ~wHave & ~bvalid;
    assign arready = ~rvalid;

    // Address and data are latched separately, so the master may send them in any order.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h00000000;
            wStrbQ <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `PRD_RESP_OKAY;
            ctrlWord <= `PRD_CONFIG_RESET;
        end else begin
            if (awvalid && awready) begin
                awHave <= 1'b1;
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wHave <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (awHave && wHave && !bvalid) begin
                awHave <= 1'b0;
                wHave <= 1'b0;
                bvalid <= 1'b1;
                bresp <= `PRD_RESP_OKAY;
                if (awAddrQ == `PRD_ADDR_CONFIG) begin
                    if (wStrbQ[0]) begin
                        ctrlWord[7:0] <= wDataQ[7:0];
                    end
                    if (wStrbQ[1]) begin
                        ctrlWord[8] <= wDataQ[8];
                    end
                end else if (awAddrQ == `PRD_ADDR_COUNT) begin
                    bresp <= `PRD_RESP_OKAY;
                end else if (awAddrQ == `PRD_ADDR_STATUS) begin
                    bresp <= `PRD_RESP_OKAY;
                end else begin
                    bresp <= `PRD_RESP_SLVERR;
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Count and status are sampled at the edge that takes the read address.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `PRD_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= `PRD_RESP_OKAY;
            if (araddr == `PRD_ADDR_CONFIG) begin
                rdata <= {23'h000000, ctrlWord};
            end else if (araddr == `PRD_ADDR_COUNT) begin
                rdata <= errorCount;
            end else if (araddr == `PRD_ADDR_STATUS) begin
                rdata <= {28'h0000000, clearNow, filtClr, curB, curA};
            end else begin
                rdata <= 32'h00000000;
                rresp <= `PRD_RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

//--- hdl/prd_map.vh
// Register map, field layout, codes and timing constants of the pulse reference decoder.
// Function
// R01: Form 0 is sign plus pulse, active high; form 5 is the same, inverted.
// R02: Form 1 counts forward and reverse pulses on two inputs; form 6 inverted.
// R03: Form 2 decodes quadrature once per cycle; form 7 is the inverted version.
// R04: Form 3 decodes quadrature twice per cycle; form 8 is the inverted version.
// R05: Form 4 counts every edge of both phases; form 9 is the inverted version.
// R06: Clear form 0 holds counter cleared while input high; form 2 while low.
// R07: Clear form 1 clears the counter once on each rising clear edge.
// R08: Clear form 3 clears the counter once on each falling clear edge.
// R09: Clear operation 0 also clears the counter while the drive is base-blocked.
// R10: Clear operation 1 never clears by itself; only the clear input does.
// R11: Clear operation 2 also clears the counter while an alarm is raised.
// R12: Filter select 0 suits line-driver inputs, 1 suits open-collector inputs.
// R13: Clear operation 3 ignores the external clear input entirely.
// R14: Counter adds one per forward count and subtracts one per reverse count.
`ifndef PRD_MAP_VH
`define PRD_MAP_VH

`define PRD_ADDR_CONFIG 8'h00
`define PRD_ADDR_COUNT 8'h04
`define PRD_ADDR_STATUS 8'h08

`define PRD_FORM_LSB 0
`define PRD_FORM_MSB 3
`define PRD_CLRSIG_LSB 4
`define PRD_CLRSIG_MSB 5
`define PRD_CLROP_LSB 6
`define PRD_CLROP_MSB 7
`define PRD_FILT_BIT 8
`define PRD_CONFIG_RESET 9'h000

`define PRD_FORM_SIGN 4'h0
`define PRD_FORM_CWCCW 4'h1
`define PRD_FORM_QX1 4'h2
`define PRD_FORM_QX2 4'h3
`define PRD_FORM_QX4 4'h4
`define PRD_FORM_NEG_FIRST 4'h5
`define PRD_FORM_NEG_LAST 4'h9

`define PRD_CLRSIG_HIGH 2'h0
`define PRD_CLRSIG_RISE 2'h1
`define PRD_CLRSIG_LOW 2'h2
`define PRD_CLRSIG_FALL 2'h3

`define PRD_CLROP_BASEBLOCK 2'h0
`define PRD_CLROP_NONE 2'h1
`define PRD_CLROP_ALARM 2'h2
`define PRD_CLROP_IGNORE 2'h3

`define PRD_CLK_MHZ 40
`define PRD_FILT_LD_NS 50
`define PRD_FILT_OC_NS 250
`define PRD_FILT_LD_CYC ((`PRD_FILT_LD_NS * `PRD_CLK_MHZ + 999) / 1000)
`define PRD_FILT_OC_CYC ((`PRD_FILT_OC_NS * `PRD_CLK_MHZ + 999) / 1000)

`define PRD_RESP_OKAY 2'h0
`define PRD_RESP_SLVERR 2'h2

`endif

//--- testbench/prd_decoder_monitor.sv
// Port checker for the pulse reference decoder.
`timescale 1ns/1ps
module prd_decoder_monitor (
    input wire clk,
    input wire reset_n,
    input wire [7:0] awaddr,
    input wire awvalid,
    input wire awready,
    input wire [31:0] wdata,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    input wire rready,
    input wire baseBlock,
    input wire alarm,
    input wire [31:0] errorCount
);
    reg [1:0] op;
    wire wrTake = awvalid & awready & wvalid & wready;
    // Shadow of the clear operation; writes taken on split edges are not followed.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            op <= 2'h0;
        end else if (wrTake && awaddr == 8'h00) begin
            op <= wdata[7:6];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_count_step: assert property ($changed(errorCount) |-> errorCount == 32'h0
        || errorCount - $past(errorCount) == 32'h1 || $past(errorCount) - errorCount == 32'h1)
        else $error("count jumped");
    a_base_clear: assert property ((op == 2'h0 && baseBlock)[*8] |-> errorCount == 32'h0)
        else $error("base block kept count");
    a_alarm_clear: assert property ((op == 2'h2 && alarm)[*8] |-> errorCount == 32'h0)
        else $error("alarm kept count");
    a_clear_ignore: assert property (op == 2'h3 && errorCount > 32'h1
        && errorCount < 32'hFFFFFFFF |=> errorCount != 32'h0)
        else $error("count cleared while ignored");
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    a_rvalid_hold: assert property (rvalid && !rready |=> rvalid)
        else $error("read answer dropped");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_write_answer: assert property (wrTake |=> ##1 bvalid && !awready && !wready)
        else $error("write answer late");
endmodule

bind prd_decoder prd_decoder_monitor i_prd_decoder_monitor (.clk, .reset_n, .awaddr, .awvalid,
    .awready, .wdata, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid,
    .rready, .baseBlock, .alarm, .errorCount);

//--- testbench/prd_pulse_source.sv
// Motion controller model emitting reference pulses in every format.
`timescale 1ns/1ps
module prd_pulse_source (
    input wire clk,
    output reg pulseA,
    output reg pulseB
);
    reg inv = 1'b0;
    int hold = 12;
    initial begin
        pulseA = 1'b0;
        pulseB = 1'b0;
    end
    // Each level stands longer than the slow filter unless a test shortens it.
    task automatic put(input bit a, input bit b);
        pulseA <= a ^ inv;
        pulseB <= b ^ inv;
        repeat (hold) @(posedge clk);
    endtask
    task automatic setPol(input bit v);
        inv = v;
        put(1'b0, 1'b0);
    endtask
    task automatic send(input int f, input bit rv, input int n);
        int g;
        int k;
        bit a;
        bit b;
        g = f % 5;
        if (g == 0) put(1'b0, rv);
        repeat (n) begin
            for (k = 0; k < ((g < 2) ? 2 : 4); k++) begin
                a = (g == 0) ? (k == 0) : (g == 1) ? (k == 0 && !rv) : (k < 2);
                b = (g == 0) ? rv : (g == 1) ? (k == 0 && rv) : (k == 1 || k == 2);
                if (g > 1 && rv) put(b, a);
                else put(a, b);
            end
        end
    endtask
endmodule

//--- testbench/prd_decoder_tb_top.sv
// Self-checking bench for the pulse reference decoder.
`timescale 1ns/1ps
module prd_decoder_tb_top;
    logic clk = 1'b0, reset_n = 1'b0, errorClearInput = 1'b0, baseBlock = 1'b0, alarm = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, d;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, pulseA, pulseB;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, errorCount;
    int errors = 0, checked = 0, f, m;
    prd_decoder i_prd_decoder (
        .clk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .pulseA, .pulseB, .errorClearInput, .baseBlock, .alarm, .errorCount
    );
    prd_pulse_source i_prd_pulse_source (.clk, .pulseA, .pulseB);
    always #12.5 clk = ~clk;
    task automatic give_verdict;
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int t);
        if (t == 50) begin
            errors++;
            $display("[ERR] %0t no bus answer", $time);
        end
    endtask
    // Handshakes are judged at the falling edge, where the rising edge's outputs have settled.
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
        int t;
        logic awT, wT, bT;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(negedge clk);
            awT = awvalid & awready;
            wT = wvalid & wready;
            bT = bvalid & bready;
            r = bresp;
            @(posedge clk);
            if (awT) awvalid <= 1'b0;
            if (wT) wvalid <= 1'b0;
            if (bT) break;
        end
        hang(t);
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axiRead(input logic [7:0] a);
        int t;
        logic arT, rT;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(negedge clk);
            arT = arvalid & arready;
            rT = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (arT) arvalid <= 1'b0;
            if (rT) break;
        end
        hang(t);
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cfg(input logic [8:0] v);
        axiWrite(8'h00, {23'h0, v});
    endtask
    // Fifteen cycles outlast either filter plus the counter update.
    task automatic drive(input logic c, input logic bb, input logic al);
        errorClearInput <= c;
        baseBlock <= bb;
        alarm <= al;
        repeat (15) @(posedge clk);
    endtask
    task automatic pulses(input int fm, input bit rv, input int n, input logic [31:0] exp);
        i_prd_pulse_source.send(fm, rv, n);
        cmpVal(errorCount, exp);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        axiRead(8'h00);
        cmpVal(d, 32'h0);
        cmpVal({30'h0, r}, 32'h0);
        axiWrite(8'h00, 32'hFFFFFFFF);
        cmpVal({30'h0, r}, 32'h0);
        axiRead(8'h00);
        cmpVal(d, 32'h1FF);
        axiWrite(8'h0C, 32'h1);
        cmpVal({30'h0, r}, 32'h2);
        axiRead(8'h0C);
        cmpVal({30'h0, r}, 32'h2);
        for (f = 0; f < 10; f++) begin
            m = (f % 5 == 3) ? 2 : (f % 5 == 4) ? 4 : 1;
            cfg({f[0], 2'h1, 2'h0, f[3:0]});
            i_prd_pulse_source.setPol(f > 4);
            drive(1'b1, 1'b0, 1'b0);
            drive(1'b0, 1'b0, 1'b0);
            cmpVal(errorCount, 32'h0);
            pulses(f, 1'b0, 3, 32'(3 * m));
            pulses(f, 1'b1, 1, 32'(2 * m));
        end
        i_prd_pulse_source.setPol(1'b0);
        cfg(9'h141);
        drive(1'b1, 1'b0, 1'b0);
        drive(1'b0, 1'b0, 1'b0);
        i_prd_pulse_source.hold = 5;
        pulses(1, 1'b0, 1, 32'h0);
        cfg(9'h041);
        pulses(1, 1'b0, 1, 32'h1);
        i_prd_pulse_source.hold = 12;
        cfg(9'h051);
        drive(1'b1, 1'b0, 1'b0);
        cmpVal(errorCount, 32'h0);
        pulses(1, 1'b0, 2, 32'h2);
        drive(1'b0, 1'b0, 1'b0);
        cfg(9'h071);
        drive(1'b1, 1'b0, 1'b0);
        cmpVal(errorCount, 32'h2);
        drive(1'b0, 1'b0, 1'b0);
        cmpVal(errorCount, 32'h0);
        cfg(9'h061);
        pulses(1, 1'b0, 2, 32'h0);
        drive(1'b1, 1'b0, 1'b0);
        pulses(1, 1'b0, 2, 32'h2);
        drive(1'b1, 1'b1, 1'b1);
        cmpVal(errorCount, 32'h2);
        cfg(9'h021);
        drive(1'b1, 1'b1, 1'b0);
        cmpVal(errorCount, 32'h0);
        drive(1'b1, 1'b0, 1'b0);
        pulses(1, 1'b0, 2, 32'h2);
        cfg(9'h0A1);
        drive(1'b1, 1'b0, 1'b1);
        cmpVal(errorCount, 32'h0);
        drive(1'b1, 1'b0, 1'b0);
        pulses(1, 1'b0, 3, 32'h3);
        cfg(9'h0C1);
        drive(1'b0, 1'b0, 1'b0);
        drive(1'b1, 1'b0, 1'b0);
        cmpVal(errorCount, 32'h3);
        axiRead(8'h04);
        cmpVal(d, 32'h3);
        axiRead(8'h08);
        cmpVal(d, 32'h4);
        give_verdict();
    end
endmodule
